//--- include/hpb_regs.vh
// register offsets, reset values and field positions of the host parallel port
`ifndef HPB_REGS_VH
`define HPB_REGS_VH
// register select codes
`define HPB_SEL_MODE_A 4'h0
`define HPB_SEL_STAT_A 4'h1
`define HPB_SEL_DATA_A 4'h3
`define HPB_SEL_IN_CHG 4'h4
`define HPB_SEL_INT_STAT 4'h5
`define HPB_SEL_INT_MASK 4'h5
`define HPB_SEL_MODE_B 4'h8
`define HPB_SEL_STAT_B 4'h9
`define HPB_SEL_DATA_B 4'hb
`define HPB_SEL_OP_CFG 4'hd
`define HPB_SEL_OP_SET 4'he
`define HPB_SEL_OP_CLR 4'hf
// reset values
`define HPB_ZERO8 8'h00
`define HPB_ONES8 8'hff
`define HPB_IDLE_RD 8'hff
// status fields
`define HPB_ST_RXRDY 0
`define HPB_ST_TXRDY 2
// interrupt status fields
`define HPB_IS_TXA 0
`define HPB_IS_RXA 1
`define HPB_IS_TXB 4
`define HPB_IS_RXB 5
// serial frame
`define HPB_BITS_PER_CHAR 4'h8
`define HPB_FRAME_BITS 4'ha
`define HPB_MARK 1'b1
`endif

//--- logic/hpb_serial_chan.v
// one serial channel: lsb-first transmitter and receiver on a bit-rate enable
`timescale 1ns/1ps
`default_nettype none
`include "hpb_regs.vh"
module hpb_serial_chan (
	// clock and reset
	input wire i_clk,
	input wire i_nrst,
	input wire i_bit_en,
	// transmit side
	input wire i_tx_start,
	input wire [7:0] i_tx_data,
	output wire o_tx_busy,
	output reg o_serial_out,
	// receive side
	input wire i_serial_in,
	output reg o_rx_strobe,
	output reg [7:0] o_rx_data
);
reg [9:0] tx_shift;
reg [3:0] tx_cnt;
reg [2:0] rx_sync;
reg rx_busy;
reg [3:0] rx_cnt;
reg [7:0] rx_shift;
assign o_tx_busy = (tx_cnt != 4'h0);
////////////////////////////////////////////////////////////////////////
// transmitter: start, eight data bits lsb first, stop; idle at mark
always @(posedge i_clk) begin
	if (!i_nrst) begin
		tx_shift <= 10'h3ff;
		tx_cnt <= 4'h0;
		o_serial_out <= `HPB_MARK;
	end else if (tx_cnt == 4'h0) begin
		o_serial_out <= `HPB_MARK;
		if (i_tx_start) begin
			tx_shift <= {1'b1, i_tx_data, 1'b0};
			tx_cnt <= `HPB_FRAME_BITS;
		end
	end else if (i_bit_en) begin
		o_serial_out <= tx_shift[0];
		tx_shift <= {1'b1, tx_shift[9:1]};
		tx_cnt <= tx_cnt - 4'h1;
	end
end
////////////////////////////////////////////////////////////////////////
// receiver: three-stage sync, sample once per bit enable, lsb first
always @(posedge i_clk) begin
	if (!i_nrst) begin
		rx_sync <= 3'h7;
		rx_busy <= 1'b0;
		rx_cnt <= 4'h0;
		rx_shift <= `HPB_ZERO8;
		o_rx_data <= `HPB_ZERO8;
		o_rx_strobe <= 1'b0;
	end else begin
		rx_sync <= {rx_sync[1:0], i_serial_in};
		o_rx_strobe <= 1'b0;
		if (i_bit_en && (rx_sync[1] == rx_sync[2])) begin
			if (!rx_busy) begin
				// a low line at the sample point is taken as start
				if (!rx_sync[2]) begin
					rx_busy <= 1'b1;
					rx_cnt <= 4'h0;
				end
			end else if (rx_cnt < `HPB_BITS_PER_CHAR) begin
				rx_shift <= {rx_sync[2], rx_shift[7:1]};
				rx_cnt <= rx_cnt + 4'h1;
			end else begin
				// stop slot: character complete
				rx_busy <= 1'b0;
				o_rx_data <= rx_shift;
				o_rx_strobe <= 1'b1;
			end
		end
	end
end
endmodule // hpb_serial_chan
`default_nettype wire

//--- logic/hpb_host_port.v
// strobe-style host parallel port with reset effects, interrupt and two channels
`timescale 1ns/1ps
`default_nettype none
`include "hpb_regs.vh"
// What this block does
// - bus select high uses separate read and write strobe interface
// - eight-bit three-state data bus, bit zero least significant
// - transfers only while chip select low; strobes and select steer them
// - chip select high releases all eight data lines
// - written value loads addressed register on write strobe rising edge
// - read strobe and chip select low drive addressed register contents
// - four register-select lines pick the register or port accessed
// - reset clears both status, mask, interrupt status, output and config
// - reset drives all general outputs high and halts the timer
// - reset idles both channels with transmit outputs at mark
// - reset points the mode pointer at the first mode register
// - open-drain interrupt pulled low while any masked condition true
// - receivers take least significant bit first
// - transmitters send lsb first, mark when idle or in reset
module hpb_host_port #(
	parameter BIT_DIV = 16'd1085
) (
	// clock and reset
	input wire i_clk,
	input wire i_nrst,
	// bus configuration
	input wire i_bus_select,
	// host bus
	input wire i_chip_select_n,
	input wire i_read_strobe_n,
	input wire i_write_strobe_n,
	input wire [3:0] i_register_select,
	input wire [7:0] i_data,
	output reg [7:0] o_data,
	output wire [7:0] o_data_oe,
	// interrupt, open drain
	output wire o_interrupt_request_n,
	output wire o_interrupt_request_n_oe,
	// general outputs, timer state and mode pointer
	output wire [7:0] o_general_output,
	output reg o_timer_running,
	output reg o_mode_ptr_a,
	output reg o_mode_ptr_b,
	// serial pins
	input wire i_serial_in_a,
	input wire i_serial_in_b,
	output wire o_serial_out_a,
	output wire o_serial_out_b
);
////////////////////////////////////////////////////////////////////////
// pin synchronisers: three stages, a change counts when stages two and three agree
reg [2:0] cs_s, rd_s, wr_s, bs_s;
reg cs_q, rd_q, wr_q, bs_q;
reg [3:0] sel_s1, sel_s2, sel_s3, sel_q2;
reg [7:0] din_s1, din_s2, din_s3, din_q2;
reg [3:0] wr_sel;
reg [7:0] wr_val;
always @(posedge i_clk) begin
	if (!i_nrst) begin
		cs_s <= 3'h7;
		rd_s <= 3'h7;
		wr_s <= 3'h7;
		bs_s <= 3'h7;
		cs_q <= 1'b1;
		rd_q <= 1'b1;
		wr_q <= 1'b1;
		bs_q <= 1'b1;
		sel_s1 <= 4'h0;
		sel_s2 <= 4'h0;
		sel_s3 <= 4'h0;
		sel_q2 <= 4'h0;
		din_s1 <= `HPB_ZERO8;
		din_s2 <= `HPB_ZERO8;
		din_s3 <= `HPB_ZERO8;
		din_q2 <= `HPB_ZERO8;
	end else begin
		cs_s <= {cs_s[1:0], i_chip_select_n};
		rd_s <= {rd_s[1:0], i_read_strobe_n};
		wr_s <= {wr_s[1:0], i_write_strobe_n};
		bs_s <= {bs_s[1:0], i_bus_select};
		if (cs_s[1] == cs_s[2]) cs_q <= cs_s[2];
		if (rd_s[1] == rd_s[2]) rd_q <= rd_s[2];
		if (wr_s[1] == wr_s[2]) wr_q <= wr_s[2];
		if (bs_s[1] == bs_s[2]) bs_q <= bs_s[2];
		// select and data are held stable by the host across the strobe
		// so a word is taken whole once stages two and three agree
		sel_s1 <= i_register_select;
		sel_s2 <= sel_s1;
		sel_s3 <= sel_s2;
		if (sel_s2 == sel_s3) sel_q2 <= sel_s3;
		din_s1 <= i_data;
		din_s2 <= din_s1;
		din_s3 <= din_s2;
		if (din_s2 == din_s3) din_q2 <= din_s3;
	end
end
wire strobe_mode = bs_q;
wire sel_ok = strobe_mode && !cs_q;
wire rd_act = sel_ok && !rd_q && wr_q;
wire wr_act = sel_ok && !wr_q && rd_q;
reg wr_act_d;
wire wr_commit = wr_act_d && !wr_act && wr_q;
////////////////////////////////////////////////////////////////////////
// write capture: latch select and data while strobe low, commit on its rise
always @(posedge i_clk) begin
	if (!i_nrst) begin
		wr_act_d <= 1'b0;
		wr_sel <= 4'h0;
		wr_val <= `HPB_ZERO8;
	end else begin
		wr_act_d <= wr_act;
		if (wr_act) begin
			wr_sel <= sel_q2;
			wr_val <= din_q2;
		end
	end
end
////////////////////////////////////////////////////////////////////////
// register file
reg [7:0] status_a, status_b, int_mask, op_reg, op_cfg, mode_a, mode_b;
reg [7:0] rx_hold_a, rx_hold_b;
reg [15:0] bit_cnt;
reg bit_en;
wire rx_stb_a, rx_stb_b, tx_busy_a, tx_busy_b;
wire [7:0] rx_dat_a, rx_dat_b;
reg rd_act_d;
wire rd_end = rd_act_d && !rd_act;
wire tx_go_a = wr_commit && (wr_sel == `HPB_SEL_DATA_A);
wire tx_go_b = wr_commit && (wr_sel == `HPB_SEL_DATA_B);
// interrupt status is built from live channel state
wire [7:0] int_stat = {2'b00, status_b[`HPB_ST_RXRDY], status_b[`HPB_ST_TXRDY],
	2'b00, status_a[`HPB_ST_RXRDY], status_a[`HPB_ST_TXRDY]};
always @(posedge i_clk) begin
	if (!i_nrst) begin
		status_a <= `HPB_ZERO8;
		status_b <= `HPB_ZERO8;
		int_mask <= `HPB_ZERO8;
		op_reg <= `HPB_ZERO8;
		op_cfg <= `HPB_ZERO8;
		mode_a <= `HPB_ZERO8;
		mode_b <= `HPB_ZERO8;
		rx_hold_a <= `HPB_ZERO8;
		rx_hold_b <= `HPB_ZERO8;
		o_mode_ptr_a <= 1'b0;
		o_mode_ptr_b <= 1'b0;
		o_timer_running <= 1'b0;
		rd_act_d <= 1'b0;
	end else begin
		rd_act_d <= rd_act;
		o_timer_running <= 1'b1;
		status_a[`HPB_ST_TXRDY] <= !tx_busy_a && !tx_go_a;
		status_b[`HPB_ST_TXRDY] <= !tx_busy_b && !tx_go_b;
		// read of the holding register clears ready; a new character wins
		if (rx_stb_a) begin
			rx_hold_a <= rx_dat_a;
			status_a[`HPB_ST_RXRDY] <= 1'b1;
		end else if (rd_end && sel_q2 == `HPB_SEL_DATA_A)
			status_a[`HPB_ST_RXRDY] <= 1'b0;
		if (rx_stb_b) begin
			rx_hold_b <= rx_dat_b;
			status_b[`HPB_ST_RXRDY] <= 1'b1;
		end else if (rd_end && sel_q2 == `HPB_SEL_DATA_B)
			status_b[`HPB_ST_RXRDY] <= 1'b0;
		// mode pointer steps after a mode access
		if (rd_end && sel_q2 == `HPB_SEL_MODE_A) o_mode_ptr_a <= 1'b1;
		if (rd_end && sel_q2 == `HPB_SEL_MODE_B) o_mode_ptr_b <= 1'b1;
		if (wr_commit) begin
			case (wr_sel)
			`HPB_SEL_MODE_A: begin
				mode_a <= wr_val;
				o_mode_ptr_a <= 1'b1;
			end
			`HPB_SEL_MODE_B: begin
				mode_b <= wr_val;
				o_mode_ptr_b <= 1'b1;
			end
			`HPB_SEL_INT_MASK: int_mask <= wr_val;
			`HPB_SEL_OP_CFG: op_cfg <= wr_val;
			`HPB_SEL_OP_SET: op_reg <= op_reg | wr_val;
			`HPB_SEL_OP_CLR: op_reg <= op_reg & ~wr_val;
			default: ;
			endcase
		end
	end
end
// output pins are the complement of the port register, so reset shows high
assign o_general_output = ~op_reg;
////////////////////////////////////////////////////////////////////////
// read mux and data bus drive
reg [7:0] next_data;
always @* begin
	case (sel_q2)
	`HPB_SEL_MODE_A: next_data = mode_a;
	`HPB_SEL_STAT_A: next_data = status_a;
	`HPB_SEL_DATA_A: next_data = rx_hold_a;
	`HPB_SEL_INT_STAT: next_data = int_stat;
	`HPB_SEL_MODE_B: next_data = mode_b;
	`HPB_SEL_STAT_B: next_data = status_b;
	`HPB_SEL_DATA_B: next_data = rx_hold_b;
	`HPB_SEL_OP_CFG: next_data = op_cfg;
	default: next_data = `HPB_IDLE_RD;
	endcase
end
always @(posedge i_clk) begin
	if (!i_nrst) o_data <= `HPB_ZERO8;
	else if (rd_act) o_data <= next_data;
end
// drive only in a read with chip select low; released otherwise
assign o_data_oe = {8{rd_act && rd_act_d}};
////////////////////////////////////////////////////////////////////////
// interrupt: open drain, enable high pulls the line low
assign o_interrupt_request_n = 1'b0;
assign o_interrupt_request_n_oe = |(int_stat & int_mask);
////////////////////////////////////////////////////////////////////////
// bit-rate divider, held during reset
always @(posedge i_clk) begin
	if (!i_nrst) begin
		bit_cnt <= 16'h0000;
		bit_en <= 1'b0;
	end else if (bit_cnt == BIT_DIV - 16'd1) begin
		bit_cnt <= 16'h0000;
		bit_en <= 1'b1;
	end else begin
		bit_cnt <= bit_cnt + 16'h0001;
		bit_en <= 1'b0;
	end
end
hpb_serial_chan u_chan_a (
	.i_clk(i_clk),
	.i_nrst(i_nrst),
	.i_bit_en(bit_en),
	.i_tx_start(tx_go_a),
	.i_tx_data(wr_val),
	.o_tx_busy(tx_busy_a),
	.o_serial_out(o_serial_out_a),
	.i_serial_in(i_serial_in_a),
	.o_rx_strobe(rx_stb_a),
	.o_rx_data(rx_dat_a)
);
hpb_serial_chan u_chan_b (
	.i_clk(i_clk),
	.i_nrst(i_nrst),
	.i_bit_en(bit_en),
	.i_tx_start(tx_go_b),
	.i_tx_data(wr_val),
	.o_tx_busy(tx_busy_b),
	.o_serial_out(o_serial_out_b),
	.i_serial_in(i_serial_in_b),
	.o_rx_strobe(rx_stb_b),
	.o_rx_data(rx_dat_b)
);
endmodule // hpb_host_port
`default_nettype wire

//--- tb/hpb_port_sva.sv
// assertions on the host port pins
`timescale 1ns/1ps
`default_nettype none
module hpb_port_sva (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// host bus
	input wire logic i_bus_select,
	input wire logic i_chip_select_n,
	input wire logic i_read_strobe_n,
	input wire logic i_write_strobe_n,
	input wire logic [7:0] o_data_oe,
	// pins set by reset
	input wire logic o_interrupt_request_n,
	input wire logic o_interrupt_request_n_oe,
	input wire logic [7:0] o_general_output,
	input wire logic o_timer_running,
	input wire logic o_mode_ptr_a,
	input wire logic o_mode_ptr_b,
	input wire logic o_serial_out_a,
	input wire logic o_serial_out_b
);
////////////////////////////////////////
// one domain; six edges cover the strobe synchroniser delay
default clocking cb @(posedge i_clk); endclocking
default disable iff (!i_nrst);
a_cs_high_release: assert property (i_chip_select_n [*6] |-> o_data_oe == 8'h00)
	else $error("bus driven with chip select high");
a_oe_all_bits: assert property (o_data_oe == 8'h00 || o_data_oe == 8'hff)
	else $error("bus enables differ");
a_rd_high_release: assert property (i_read_strobe_n [*6] |-> o_data_oe == 8'h00)
	else $error("bus driven without read strobe");
a_bus_cfg_off: assert property (!i_bus_select [*6] |-> o_data_oe == 8'h00)
	else $error("bus driven with strobe bus off");
a_read_drives: assert property ((i_bus_select && !i_chip_select_n && !i_read_strobe_n
	&& i_write_strobe_n) [*8] |-> o_data_oe == 8'hff)
	else $error("read not driven");
a_reset_state: assert property ($rose(i_nrst) |-> o_general_output == 8'hff
	&& o_serial_out_a && o_serial_out_b && !o_timer_running && !o_mode_ptr_a
	&& !o_mode_ptr_b)
	else $error("reset state wrong");
a_irq_reset_off: assert property ($rose(i_nrst) |-> !o_interrupt_request_n_oe)
	else $error("interrupt pulled at reset release");
a_timer_starts: assert property ($rose(i_nrst) |=> o_timer_running)
	else $error("timer not running");
a_irq_level: assert property (o_interrupt_request_n == 1'b0)
	else $error("interrupt level wrong");
endmodule // hpb_port_sva
bind hpb_host_port hpb_port_sva chk (.i_clk, .i_nrst, .i_bus_select, .i_chip_select_n,
	.i_read_strobe_n, .i_write_strobe_n, .o_data_oe, .o_interrupt_request_n,
	.o_interrupt_request_n_oe, .o_general_output,
	.o_timer_running, .o_mode_ptr_a, .o_mode_ptr_b, .o_serial_out_a, .o_serial_out_b);
`default_nettype wire

//--- tb/hpb_host_model.sv
// host processor model making strobe bus cycles
`timescale 1ns/1ps
`default_nettype none
module hpb_host_model (
	// clock and device side
	input wire logic i_clk,
	input wire logic [7:0] i_data,
	input wire logic [7:0] i_data_oe,
	// host strobes and data
	output logic o_chip_select_n,
	output logic o_read_strobe_n,
	output logic o_write_strobe_n,
	output logic [3:0] o_register_select,
	output logic [7:0] o_data
);
////////////////////////////////////////
// idle bus, strobes high
initial begin
	o_chip_select_n = 1'b1;
	o_read_strobe_n = 1'b1;
	o_write_strobe_n = 1'b1;
	o_register_select = 4'h0;
	o_data = 8'h00;
end
// select and data stay put through the strobe; never both strobes low
task automatic wr(input logic [3:0] sel, input logic [7:0] val);
	@(negedge i_clk);
	o_register_select = sel;
	o_data = val;
	o_chip_select_n = 1'b0;
	o_write_strobe_n = 1'b0;
	repeat (10) @(negedge i_clk);
	o_write_strobe_n = 1'b1;
	repeat (2) @(negedge i_clk);
	o_chip_select_n = 1'b1;
	o_data = ~val; // released lines do not keep the value
	repeat (10) @(negedge i_clk);
endtask
// read waits a bounded time for the device to drive
task automatic rd(input logic [3:0] sel, input logic cs_n, output logic [7:0] val,
	output logic ok);
	int n;
	@(negedge i_clk);
	ok = 1'b0;
	val = 8'h00;
	o_register_select = sel;
	o_chip_select_n = cs_n;
	o_read_strobe_n = 1'b0;
	// looked at on the falling edge, where the registered outputs have settled
	for (n = 0; n < 20 && !ok; n++) begin
		@(negedge i_clk);
		if (i_data_oe === 8'hff) begin
			ok = 1'b1;
			val = i_data;
		end
	end
	// strobe stays low long enough to meet the minimum strobe width
	repeat (8) @(negedge i_clk);
	o_read_strobe_n = 1'b1;
	o_chip_select_n = 1'b1;
	repeat (10) @(negedge i_clk);
endtask
endmodule // hpb_host_model
`default_nettype wire

//--- tb/testbench.sv
// directed test of the host parallel port
`timescale 1ns/1ps
`default_nettype none
module testbench;
logic clk = 1'b0, nrst = 1'b0, bsel = 1'b1, sin_a = 1'b1, sin_b = 1'b1, ok;
logic cs_n, rd_n, wr_n, irq_n, irq_oe, tmr, mpa, mpb, sout_a, sout_b;
logic [3:0] sel;
logic [7:0] hdata, dout, oe, gen, v;
int mismatches = 0, samples_checked = 0, i;
////////////////////////////////////////
always #4 clk = ~clk;
// four clocks a bit keeps frames short
hpb_host_port #(.BIT_DIV(16'd4)) dut (.i_clk(clk), .i_nrst(nrst), .i_bus_select(bsel),
	.i_chip_select_n(cs_n), .i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n),
	.i_register_select(sel), .i_data(hdata), .o_data(dout), .o_data_oe(oe),
	.o_interrupt_request_n(irq_n), .o_interrupt_request_n_oe(irq_oe), .o_general_output(gen),
	.o_timer_running(tmr), .o_mode_ptr_a(mpa), .o_mode_ptr_b(mpb), .i_serial_in_a(sin_a),
	.i_serial_in_b(sin_b), .o_serial_out_a(sout_a), .o_serial_out_b(sout_b));
hpb_host_model host (.i_clk(clk), .i_data(dout), .i_data_oe(oe), .o_chip_select_n(cs_n),
	.o_read_strobe_n(rd_n), .o_write_strobe_n(wr_n), .o_register_select(sel), .o_data(hdata));
task automatic check8(input logic [7:0] got, input logic [7:0] exp);
	samples_checked++;
	if (got !== exp) begin
		mismatches++;
		$display("wrong value at %0t: got %h expected %h", $time, got, exp);
	end
endtask
task automatic print_verdict;
	if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
	else $display("RESULT: FAIL");
	$finish;
endtask
// reset held five cycles, pins checked while held
task automatic do_reset;
	@(negedge clk);
	nrst = 1'b0;
	repeat (5) @(negedge clk);
	check8({sout_a, sout_b, tmr, mpa, mpb, irq_oe, 2'b00}, 8'hc0);
	check8(gen, 8'hff);
	check8(oe, 8'h00);
	nrst = 1'b1;
	repeat (6) @(negedge clk);
endtask
// start bit, then data lsb first, then stop, sampled mid bit
task automatic tx_check(input logic [7:0] exp);
	for (i = 0; i < 100 && sout_a !== 1'b0; i++) @(negedge clk);
	if (i == 100) begin
		mismatches++;
		print_verdict();
	end
	repeat (2) @(negedge clk);
	for (int b = 0; b < 9; b++) begin
		repeat (4) @(negedge clk);
		check8(sout_a, b < 8 ? exp[b] : 1'b1);
	end
endtask
// same character on both receive lines, lsb first
task automatic send_ab(input logic [7:0] val);
	sin_a = 1'b0;
	sin_b = 1'b0;
	repeat (4) @(negedge clk);
	for (int b = 0; b < 8; b++) begin
		sin_a = val[b];
		sin_b = val[b];
		repeat (4) @(negedge clk);
	end
	sin_a = 1'b1;
	sin_b = 1'b1;
	repeat (8) @(negedge clk);
endtask
initial begin
	do_reset();
	check8(tmr, 1'b1);
	host.wr(4'he, 8'h0f);
	check8(gen, 8'hf0);
	host.wr(4'hf, 8'h03);
	check8(gen, 8'hf3);
	host.rd(4'h2, 1'b0, v, ok);
	check8(ok, 1'b1);
	check8(v, 8'hff);
	host.rd(4'h2, 1'b1, v, ok);
	check8(ok, 1'b0);
	bsel = 1'b0;
	host.rd(4'h2, 1'b0, v, ok);
	check8(ok, 1'b0);
	bsel = 1'b1;
	fork
		host.wr(4'h3, 8'ha5);
		tx_check(8'ha5);
	join
	// starting one negedge after the stop bit puts every bit between two enables
	@(negedge clk);
	send_ab(8'h3c);
	host.rd(4'hb, 1'b0, v, ok);
	check8(ok, 1'b1);
	check8(v, 8'h3c);
	host.rd(4'h3, 1'b0, v, ok);
	check8(ok, 1'b1);
	check8(v, 8'h3c);
	host.wr(4'h5, 8'h01);
	check8(irq_oe, 1'b1);
	host.wr(4'h5, 8'h00);
	check8(irq_oe, 1'b0);
	check8(mpa, 1'b0);
	host.rd(4'h0, 1'b0, v, ok);
	check8(mpa, 1'b1);
	host.wr(4'h5, 8'hff);
	check8(irq_oe, 1'b1);
	do_reset();
	check8(irq_oe, 1'b0);
	host.wr(4'h5, 8'hff);
	check8(irq_oe, 1'b1);
	print_verdict();
end
endmodule // testbench
`default_nettype wire
